// ---- rtl/esl_pkg.sv ----
// constants and types shared by the start-up, indicator and buffer logic
package esl_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLOCK_KHZ       = 25000;     // primary clock, 25 MHz
    localparam int STARTUP_TIME_US = 1000;      // transceiver settle time, 1 ms
    localparam int STARTUP_CYCLES  = (CLOCK_KHZ * STARTUP_TIME_US + 999) / 1000;
    localparam int TICK_TIME_US    = 1000;      // stretch time base, 1 ms
    localparam int TICK_CYCLES     = (CLOCK_KHZ * TICK_TIME_US + 999) / 1000;

    // ************************************************************
    // indicator stretch lengths in milliseconds
    // ************************************************************
    localparam int        STRETCH_W         = 8;
    localparam logic [7:0] STRETCH_NORMAL_MS = 8'h28;   // 40 ms
    localparam logic [7:0] STRETCH_MEDIUM_MS = 8'h46;   // 70 ms
    localparam logic [7:0] STRETCH_LONG_MS   = 8'h8C;   // 140 ms

    // ************************************************************
    // packet buffer
    // ************************************************************
    localparam int BUF_BYTES  = 8192;           // 8 Kbytes
    localparam int BUF_ADDR_W = 13;
    localparam int NUM_REQ    = 4;
    localparam int REQ_CORE   = 0;
    localparam int REQ_DMA    = 1;
    localparam int REQ_TX     = 2;
    localparam int REQ_RX     = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RESET_READY = 1'b0;
    localparam logic RESET_LED   = 1'b0;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        ESL_ST_OFF   = 2'b00,
        ESL_ST_WAIT  = 2'b01,
        ESL_ST_READY = 2'b10
    } esl_state_t;

    typedef enum logic [1:0] {
        ESL_STRETCH_NORMAL = 2'b00,
        ESL_STRETCH_MEDIUM = 2'b01,
        ESL_STRETCH_LONG   = 2'b10
    } esl_stretch_t;

    typedef enum logic [1:0] {
        ESL_IND_LINK = 2'b00,      // link status level
        ESL_IND_ACT  = 2'b01,      // receive or transmit activity
        ESL_IND_RX   = 2'b10,      // receive activity
        ESL_IND_TX   = 2'b11       // transmit activity
    } esl_ind_mode_t;

endpackage

// ---- rtl/esl_stretch.sv ----
// pulse stretcher for one indicator output
`timescale 1ns/100ps

module esl_stretch
    import esl_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    input  wire logic                 tick_in,       // 1 ms enable pulse
    input  wire logic                 event_in,      // one-cycle or level activity
    input  wire logic                 enable_in,     // stretching on
    input  wire logic [STRETCH_W-1:0] length_ms_in,
    output logic                      active_out
);
    import esl_pkg::*;

    logic [STRETCH_W-1:0] count_reg;
    logic [STRETCH_W-1:0] count_next;
    logic                 active_reg;
    logic                 active_next;

    // reload on every event, count down once per millisecond
    always_comb begin
        count_next = count_reg;
        if (!enable_in) begin
            count_next = '0;
        end else if (event_in) begin
            count_next = length_ms_in; // R8
        end else if (tick_in && count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
        active_next = event_in || (count_next != '0);
    end

    // state registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            count_reg  <= '0;
            active_reg <= RESET_LED;
        end else begin
            count_reg  <= count_next;
            active_reg <= active_next;
        end
    end

    assign active_out = active_reg;

endmodule

// ---- rtl/esl_ethernet_startup.sv ----
// start-up timer, indicator pin control and packet buffer arbiter of the ethernet module
// How it works
// R1: clearing enable clears the ready flag
// R2: setting enable starts a dedicated start-up counter
// R3: ready flag sets after 1 ms automatically
// R4: firmware polls ready before network operation
// R5: pins show indicators only when function selected
// R6: firmware makes indicator pins sourcing outputs
// R7: each indicator selects link or activity display
// R8: short events stretched 40, 70 or 140 ms
// R9: module runs only from 25 MHz primary clock
// R10: firmware disables module outside primary-oscillator modes
// R11: arbiter shares buffer among four requesters
// R12: module owns an 8 Kbyte packet buffer
// R13: no digital port to an external transceiver
// R14: 25000-cycle count, restarted on each enable rise
`timescale 1ns/100ps

module esl_ethernet_startup
    import esl_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES,   // shorten in simulation
    parameter int TICK_CNT    = TICK_CYCLES,      // shorten in simulation
    parameter int ADDR_W      = BUF_ADDR_W,
    parameter int DEPTH       = BUF_BYTES
) (
    input  wire logic                          clock_in,     // 25 MHz primary clock only
    input  wire logic                          rst_in,
    // start-up control and status
    input  wire logic                          module_enable_bit_in,
    output logic                               transceiver_ready_flag_out,
    // indicator configuration and events
    input  wire logic                          indicator_function_select_in,
    input  wire esl_pkg::esl_ind_mode_t        indicator_mode_a_in,
    input  wire esl_pkg::esl_ind_mode_t        indicator_mode_b_in,
    input  wire logic                          stretch_enable_in,
    input  wire esl_pkg::esl_stretch_t         stretch_select_in,
    input  wire logic                          link_up_in,
    input  wire logic                          rx_activity_in,
    input  wire logic                          tx_activity_in,
    // port a pins 0 and 1
    input  wire logic [1:0]                    port_a_data_in,
    input  wire logic [1:0]                    port_a_direction_in,
    input  wire logic [1:0]                    port_a_pin_in,
    output logic      [1:0]                    port_a_pin_out,
    output logic      [1:0]                    port_a_pin_oe_out,
    output logic      [1:0]                    port_a_pin_sampled_out,
    // packet buffer requesters: core, dma, transmit, receive
    input  wire logic [esl_pkg::NUM_REQ-1:0]   buf_req_in,
    input  wire logic [esl_pkg::NUM_REQ-1:0]   buf_write_in,
    input  wire logic [esl_pkg::NUM_REQ*ADDR_W-1:0] buf_addr_in,
    input  wire logic [esl_pkg::NUM_REQ*8-1:0] buf_wdata_in,
    output logic      [esl_pkg::NUM_REQ-1:0]   buf_grant_out,
    output logic      [7:0]                    buf_rdata_out
);
    import esl_pkg::*;

    // ************************************************************
    // start-up timer
    // ************************************************************
    esl_state_t  state_reg;
    esl_state_t  state_next;
    logic [31:0] su_count_reg;
    logic [31:0] su_count_next;
    logic        enable_prev_reg;
    logic        ready_reg;
    logic        ready_next;

    // a rising enable always restarts the count, even from ready
    always_comb begin
        state_next    = state_reg;
        su_count_next = su_count_reg;
        ready_next    = ready_reg;
        if (!module_enable_bit_in) begin
            state_next    = ESL_ST_OFF;
            su_count_next = '0;
            ready_next    = 1'b0; // R1
        end else if (!enable_prev_reg) begin
            state_next    = ESL_ST_WAIT; // R2
            su_count_next = '0; // R14
            ready_next    = 1'b0;
        end else begin
            unique case (state_reg)
                ESL_ST_OFF: begin
                    state_next    = ESL_ST_WAIT;
                    su_count_next = '0;
                end
                ESL_ST_WAIT: begin
                    if (su_count_reg == 32'(STARTUP_CNT - 1)) begin
                        state_next = ESL_ST_READY;
                        ready_next = 1'b1; // R3
                    end else begin
                        su_count_next = su_count_reg + 32'h1; // R14
                    end
                end
                ESL_ST_READY: begin
                    ready_next = 1'b1;
                end
                default: begin
                    state_next = ESL_ST_OFF;
                    ready_next = 1'b0;
                end
            endcase
        end
    end

    // start-up registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg       <= ESL_ST_OFF;
            su_count_reg    <= '0;
            enable_prev_reg <= 1'b0;
            ready_reg       <= RESET_READY;
        end else begin
            state_reg       <= state_next;
            su_count_reg    <= su_count_next;
            enable_prev_reg <= module_enable_bit_in;
            ready_reg       <= ready_next;
        end
    end

    assign transceiver_ready_flag_out = ready_reg;

    // ************************************************************
    // millisecond tick for indicator stretching
    // ************************************************************
    logic [31:0] tick_count_reg;
    logic [31:0] tick_count_next;
    logic        tick_reg;
    logic        tick_next;

    // free-running divider, one-cycle enable every millisecond
    always_comb begin
        tick_next = (tick_count_reg == 32'(TICK_CNT - 1));
        if (tick_next) begin
            tick_count_next = '0;
        end else begin
            tick_count_next = tick_count_reg + 32'h1;
        end
    end

    // divider registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            tick_count_reg <= '0;
            tick_reg       <= 1'b0;
        end else begin
            tick_count_reg <= tick_count_next;
            tick_reg       <= tick_next;
        end
    end

    // ************************************************************
    // indicator outputs
    // ************************************************************
    logic [STRETCH_W-1:0] length_ms;
    esl_ind_mode_t        mode_sel [2];
    logic [1:0]           ind_level;
    logic [1:0]           pin_out_next;
    logic [1:0]           pin_oe_next;
    logic [1:0]           pin_out_reg;
    logic [1:0]           pin_oe_reg;
    logic [1:0]           pin_sync1_reg;
    logic [1:0]           pin_sync2_reg;

    // stretch length selection, illegal code takes the longest
    always_comb begin
        unique case (stretch_select_in)
            ESL_STRETCH_NORMAL: length_ms = STRETCH_NORMAL_MS; // R8
            ESL_STRETCH_MEDIUM: length_ms = STRETCH_MEDIUM_MS; // R8
            ESL_STRETCH_LONG:   length_ms = STRETCH_LONG_MS; // R8
            default:            length_ms = STRETCH_LONG_MS;
        endcase
    end

    assign mode_sel[0] = indicator_mode_a_in;
    assign mode_sel[1] = indicator_mode_b_in;

    // per indicator: pick the source, stretch activity, steer the pin
    for (genvar i = 0; i < 2; i++) begin : g_ind
        logic act_event;
        logic act_stretched;

        always_comb begin
            unique case (mode_sel[i])
                ESL_IND_LINK: act_event = 1'b0; // R7
                ESL_IND_ACT:  act_event = rx_activity_in || tx_activity_in; // R7
                ESL_IND_RX:   act_event = rx_activity_in; // R7
                ESL_IND_TX:   act_event = tx_activity_in; // R7
            endcase
        end

        esl_stretch u_stretch (
            .clock_in     (clock_in),
            .rst_in       (rst_in),
            .tick_in      (tick_reg),
            .event_in     (act_event),
            .enable_in    (stretch_enable_in),
            .length_ms_in (length_ms),
            .active_out   (act_stretched)
        );

        // unstretched activity follows the event itself
        always_comb begin
            if (mode_sel[i] == ESL_IND_LINK) begin
                ind_level[i] = link_up_in; // R7
            end else if (stretch_enable_in) begin
                ind_level[i] = act_stretched; // R8
            end else begin
                ind_level[i] = act_event;
            end
            // direction bit low drives the pin; sourcing means active high
            pin_oe_next[i] = !port_a_direction_in[i];
            if (indicator_function_select_in) begin
                pin_out_next[i] = ind_level[i]; // R5
            end else begin
                pin_out_next[i] = port_a_data_in[i]; // R5
            end
        end
    end

    // pin registers and input synchroniser
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_out_reg   <= '0;
            pin_oe_reg    <= '0;
            pin_sync1_reg <= '0;
            pin_sync2_reg <= '0;
        end else begin
            pin_out_reg   <= pin_out_next;
            pin_oe_reg    <= pin_oe_next;
            pin_sync1_reg <= port_a_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    assign port_a_pin_out         = pin_out_reg;
    assign port_a_pin_oe_out      = pin_oe_reg;
    assign port_a_pin_sampled_out = pin_sync2_reg;

    // ************************************************************
    // packet buffer and arbiter
    // ************************************************************
    logic [7:0]         buf_mem [DEPTH]; // R12
    logic [NUM_REQ-1:0] eligible;
    logic [NUM_REQ-1:0] grant_next;
    logic [NUM_REQ-1:0] grant_reg;
    logic [ADDR_W-1:0]  win_addr;
    logic [7:0]         win_wdata;
    logic               win_write;
    logic [7:0]         rdata_reg;

    // fixed priority, receive first so incoming data waits only through its own sit-out cycle;
    // a requester just granted sits out one cycle so its held request
    // is not served twice
    always_comb begin
        eligible   = buf_req_in & ~grant_reg;
        grant_next = '0;
        win_addr   = '0;
        win_wdata  = '0;
        win_write  = 1'b0;
        for (int r = 0; r < NUM_REQ; r++) begin
            if (eligible[r] && !(|(eligible >> (r + 1)))) begin
                grant_next[r] = 1'b1; // R11
                win_addr      = buf_addr_in[r*ADDR_W +: ADDR_W];
                win_wdata     = buf_wdata_in[r*8 +: 8];
                win_write     = buf_write_in[r];
            end
        end
    end

    // buffer access: one byte per cycle for the winner
    always_ff @(posedge clock_in) begin
        if (win_write && (grant_next != '0)) begin
            buf_mem[win_addr] <= win_wdata; // R12
        end
    end

    // arbiter registers, read data returned with the grant
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            grant_reg <= '0;
            rdata_reg <= '0;
        end else begin
            grant_reg <= grant_next;
            rdata_reg <= buf_mem[win_addr];
        end
    end

    assign buf_grant_out = grant_reg;
    assign buf_rdata_out = rdata_reg;

    // network data reaches this block only through the internal transceiver;
    // there is deliberately no digital transceiver port (R13), and the single
    // clock_in is the only clock (R9)

endmodule

// ---- verif/esl_startup_checker.sv ----
// concurrent checks on the start-up, indicator and buffer arbiter ports
`timescale 1ns/100ps

module esl_startup_checker
    import esl_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input wire logic                  clock_in,
    input wire logic                  rst_in,
    input wire logic                  module_enable_bit_in,
    input wire logic                  transceiver_ready_flag_out,
    input wire logic                  indicator_function_select_in,
    input wire esl_pkg::esl_ind_mode_t indicator_mode_a_in,
    input wire logic                  stretch_enable_in,
    input wire logic                  link_up_in,
    input wire logic                  rx_activity_in,
    input wire logic [1:0]            port_a_data_in,
    input wire logic [1:0]            port_a_direction_in,
    input wire logic [1:0]            port_a_pin_out,
    input wire logic [1:0]            port_a_pin_oe_out,
    input wire logic [3:0]            buf_req_in,
    input wire logic [3:0]            buf_grant_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ************************************************************
    // edges that enable has been seen high in a row
    // ************************************************************
    logic [15:0] hi_cnt_reg;
    logic [15:0] hi_cnt_next;

    // saturating count, cleared by any low sample
    always_comb begin
        hi_cnt_next = hi_cnt_reg;
        if (!module_enable_bit_in) begin
            hi_cnt_next = 16'h0000;
        end else if (hi_cnt_reg != 16'hFFFF) begin
            hi_cnt_next = hi_cnt_reg + 16'h0001;
        end
    end

    // register the count
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hi_cnt_reg <= 16'h0000;
        end else begin
            hi_cnt_reg <= hi_cnt_next;
        end
    end

    ready_clear_a: assert property (!rst_in && !module_enable_bit_in |=>
        !transceiver_ready_flag_out) else $error("ready flag held after disable");
    ready_early_a: assert property (transceiver_ready_flag_out |->
        hi_cnt_reg >= STARTUP_CNT + 1) else $error("ready flag set too early");
    ready_time_a: assert property ($rose(transceiver_ready_flag_out) |->
        hi_cnt_reg == STARTUP_CNT + 1) else $error("ready flag rose late");
    ready_late_a: assert property (hi_cnt_reg == STARTUP_CNT + 1 |->
        transceiver_ready_flag_out) else $error("ready flag missing after count");
    port_plain_a: assert property (!rst_in && !indicator_function_select_in |=>
        port_a_pin_out == $past(port_a_data_in)) else $error("port pins not from latch");
    pin_drive_a: assert property (!rst_in |=>
        port_a_pin_oe_out == ~$past(port_a_direction_in)) else $error("pin enable wrong");
    link_follow_a: assert property (!rst_in && indicator_function_select_in &&
        indicator_mode_a_in == ESL_IND_LINK |=> port_a_pin_out[0] == $past(link_up_in))
        else $error("indicator a not showing link");
    stretch_start_a: assert property (!rst_in && indicator_function_select_in &&
        stretch_enable_in && indicator_mode_a_in == ESL_IND_RX && rx_activity_in |->
        ##2 port_a_pin_out[0]) else $error("stretched indicator did not light");
    grant_single_a: assert property ($onehot0(buf_grant_out))
        else $error("more than one grant");
    grant_prio_a: assert property (!rst_in && buf_req_in[3] && !buf_grant_out[3] |=>
        buf_grant_out == 4'h8) else $error("receive request not served first");
    grant_gap_a: assert property (buf_grant_out[0] |=> !buf_grant_out[0])
        else $error("core granted twice in a row");
endmodule

bind esl_ethernet_startup esl_startup_checker #(.STARTUP_CNT(STARTUP_CNT)) u_chk (
    .clock_in, .rst_in, .module_enable_bit_in, .transceiver_ready_flag_out,
    .indicator_function_select_in, .indicator_mode_a_in, .stretch_enable_in, .link_up_in,
    .rx_activity_in, .port_a_data_in, .port_a_direction_in, .port_a_pin_out,
    .port_a_pin_oe_out, .buf_req_in, .buf_grant_out);

// ---- verif/esl_fw_model.sv ----
// host firmware model: enables the module, sets pin directions, polls ready
`timescale 1ns/100ps

module esl_fw_model (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       go_in,
    input  wire logic       ready_in,
    output logic            enable_out,
    output logic [1:0]      direction_out,
    output logic            net_ok_out
);
    logic       en_reg, en_next, ok_reg, ok_next;
    logic [1:0] dir_reg, dir_next;

    // module stays off unless asked, as when leaving primary run or idle
    always_comb begin
        en_next  = go_in;
        dir_next = go_in ? 2'h0 : 2'h3;
        ok_next  = go_in & en_reg & ready_in;
    end

    // register firmware state, pins start as inputs
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            en_reg  <= 1'b0;
            dir_reg <= 2'h3;
            ok_reg  <= 1'b0;
        end else begin
            en_reg  <= en_next;
            dir_reg <= dir_next;
            ok_reg  <= ok_next;
        end
    end

    assign enable_out    = en_reg;
    assign direction_out = dir_reg;
    assign net_ok_out    = ok_reg;
endmodule

// ---- verif/tb_esl_ethernet_startup.sv ----
// self-checking bench for start-up timer, indicator pins and buffer arbiter
`timescale 1ns/100ps

module tb_esl_ethernet_startup;
    import esl_pkg::*;
    localparam int SU = 10;
    localparam int TK = 5;

    logic          clk = 1'b0, rst = 1'b1, go = 1'b0, en, rdy, ok;
    logic          fsel = 1'b0, sen = 1'b0, link = 1'b0, rx = 1'b0, tx = 1'b0;
    esl_ind_mode_t ma = ESL_IND_LINK, mb = ESL_IND_LINK;
    esl_stretch_t  ssel = ESL_STRETCH_NORMAL;
    logic [1:0]    dir, pdat = 2'h0, pout, poe, psmp;
    logic [3:0]    req = 4'h0, wr = 4'h0, grant;
    logic [51:0]   addr = 52'h0;
    logic [31:0]   wdat = 32'h0;
    logic [7:0]    rdat, q;
    logic [7:0]    lens [4] = '{STRETCH_NORMAL_MS, STRETCH_MEDIUM_MS, STRETCH_LONG_MS,
                                STRETCH_LONG_MS};
    int            miscompares = 0, total_checks = 0, n;

    esl_ethernet_startup #(.STARTUP_CNT(SU), .TICK_CNT(TK)) DUT (
        .clock_in(clk), .rst_in(rst), .module_enable_bit_in(en),
        .transceiver_ready_flag_out(rdy), .indicator_function_select_in(fsel),
        .indicator_mode_a_in(ma), .indicator_mode_b_in(mb), .stretch_enable_in(sen),
        .stretch_select_in(ssel), .link_up_in(link), .rx_activity_in(rx),
        .tx_activity_in(tx), .port_a_data_in(pdat), .port_a_direction_in(dir),
        .port_a_pin_in(2'h1), .port_a_pin_out(pout), .port_a_pin_oe_out(poe),
        .port_a_pin_sampled_out(psmp), .buf_req_in(req), .buf_write_in(wr),
        .buf_addr_in(addr), .buf_wdata_in(wdat), .buf_grant_out(grant),
        .buf_rdata_out(rdat));

    esl_fw_model FW (.clock_in(clk), .rst_in(rst), .go_in(go), .ready_in(rdy),
        .enable_out(en), .direction_out(dir), .net_ok_out(ok));

    // ************************************************************
    // clock, helpers and closing
    // ************************************************************
    initial forever #20 clk = ~clk;

    task tick();
        @(posedge clk);
        #1;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // enable, time the ready flag, then disable
    task startup();
        @(posedge clk) go <= 1'b1;
        tick();
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        chk(n == SU + 1, 1'b1);
        tick();
        chk(ok, 1'b1);
        @(posedge clk) go <= 1'b0;
        tick();
        tick();
        chk(rdy, 1'b0);
    endtask

    // one buffer access by requester r, held until its grant
    task buf_op(input int r, input logic w, input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        req[r] <= 1'b1;
        wr[r] <= w;
        addr[r*13 +: 13] <= a;
        wdat[r*8 +: 8] <= d;
        n = 0;
        do begin
            tick();
            n++;
        end while (grant[r] !== 1'b1 && n < 20);
        q = rdat;
        chk(n < 20, 1'b1);
        @(posedge clk) req[r] <= 1'b0;
    endtask

    initial begin
        #400000;
        miscompares++;
        end_sim();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        startup();
        startup();
        $display("test startup done");
        @(posedge clk) pdat <= 2'h2;
        tick();
        tick();
        chk(pout, 2'h2);
        chk(poe, 2'h0);
        chk(psmp, 2'h1);
        @(posedge clk) fsel <= 1'b1;
        link <= 1'b1;
        go <= 1'b1;
        repeat (3) tick();
        chk(pout, 2'h3);
        chk(poe, 2'h3);
        @(posedge clk) link <= 1'b0;
        tick();
        tick();
        chk(pout, 2'h0);
        $display("test pins done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) ma <= ESL_IND_RX;
            mb <= esl_ind_mode_t'(s[1:0]);
            sen <= 1'b1;
            ssel <= esl_stretch_t'(s[1:0]);
            rx <= 1'b1;
            tx <= (s == 3);
            @(posedge clk) rx <= 1'b0;
            tx <= 1'b0;
            tick();
            chk(pout[1], s != 0);
            n = 0;
            while (pout[0] === 1'b1 && n < 800) begin
                tick();
                n++;
            end
            chk(n > (lens[s] - 1) * TK && n <= lens[s] * TK, 1'b1);
        end
        // stretching off: the indicator follows the event for one cycle only
        @(posedge clk) sen <= 1'b0;
        rx <= 1'b1;
        @(posedge clk) rx <= 1'b0;
        #1;
        chk(pout[0], 1'b1);
        tick();
        chk(pout[0], 1'b0);
        $display("test stretch done");
        for (int r = 0; r < 4; r++) buf_op(r, 1'b1, 13'h1FFF - r[12:0], 8'hA0 + r[7:0]);
        for (int r = 0; r < 4; r++) begin
            buf_op((r + 1) % 4, 1'b0, 13'h1FFF - r[12:0], 8'h00);
            chk(q, 8'hA0 + r[7:0]);
        end
        @(posedge clk) req <= 4'h9;
        wr <= 4'h0;
        addr[12:0] <= 13'h1FFF;
        addr[51:39] <= 13'h1FFC;
        tick();
        chk(grant, 4'h8);
        chk(rdat, 8'hA3);
        @(posedge clk) req <= 4'h1;
        #1;
        chk(grant, 4'h1);
        chk(rdat, 8'hA0);
        @(posedge clk) req <= 4'h0;
        $display("test buffer done");
        end_sim();
    end
endmodule
